// ===== slf_defines.svh
// Register offsets, field layouts and reset values for the linefeed block
`ifndef SLF_DEFINES_SVH
`define SLF_DEFINES_SVH

`define SLF_ADDR_W 8
`define SLF_DATA_W 8
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define SLF_OFF_STATE 8'h40
`define SLF_OFF_LOOP_CURRENT_LIMIT 8'h47
`define SLF_OFF_VOC 8'h48
`define SLF_OFF_VCM 8'h49
`define SLF_OFF_ALARM 8'h4A
`define SLF_OFF_LOOPV 8'h4E
`define SLF_OFF_LOOPI 8'h4F
// ---------------------------------------------------------------
// Field widths
// ---------------------------------------------------------------
`define SLF_STATE_W 3
`define SLF_LOOP_CURRENT_LIMIT_W 3
`define SLF_VOC_W 6
`define SLF_VCM_W 6
`define SLF_MEAS_W 7
// ---------------------------------------------------------------
// Alarm register bit positions
// ---------------------------------------------------------------
`define SLF_ALM_FLAG_BIT 0
`define SLF_ALM_AUTO_OPEN_ENABLE_BIT 1
`define SLF_ALM_CAL_BIT 2
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define SLF_RST_STATE 3'h0
`define SLF_RST_LOOP_CURRENT_LIMIT 3'h0
`define SLF_RST_VOC 6'h20
`define SLF_RST_VCM 6'h02
// Calibration duration, ns
`define SLF_CAL_TIME_NS 1000
`define SLF_CLK_NS 4
`define SLF_CAL_CYC ((`SLF_CAL_TIME_NS + `SLF_CLK_NS - 1) / `SLF_CLK_NS)

`endif

// ===== slf_pkg.sv
// Types for the linefeed control block
package slf_pkg;
    typedef enum logic [2:0] {
        SLF_OPEN = 3'h0,
        SLF_FWD_ACT = 3'h1,
        SLF_FWD_OHT = 3'h2,
        SLF_TIP_OPEN = 3'h3,
        SLF_RINGING = 3'h4,
        SLF_REV_ACT = 3'h5,
        SLF_REV_OHT = 3'h6,
        SLF_RING_OPEN = 3'h7
    } slf_line_state_e;

    typedef struct packed {
        logic tip_drive;
        logic ring_drive;
        logic feed_on;
        logic audio_on;
        logic ringing_on;
        logic reverse;
    } slf_drive_s;
endpackage

// ===== slf_drive_if.sv
// Drive controls passed from the state decoder to the top
`timescale 1ns/1ps
`default_nettype none
interface slf_drive_if;
    slf_pkg::slf_drive_s drv;
    modport src (output drv);
    modport dst (input drv);
endinterface
`default_nettype wire

// ===== slf_state_decode.sv
// Line state code to driver control decoder
`timescale 1ns/1ps
`default_nettype none
module slf_state_decode
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [2:0] state_code,
    slf_drive_if.src out
);
    slf_pkg::slf_drive_s drv_d;
    slf_pkg::slf_drive_s drv_q;

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    always_comb
    begin
        drv_d = '0;
        unique case (slf_pkg::slf_line_state_e'(state_code)) // RULE2
            slf_pkg::SLF_OPEN:
            begin
                drv_d = '0; // RULE3
            end
            slf_pkg::SLF_FWD_ACT, slf_pkg::SLF_REV_ACT:
            begin
                drv_d.tip_drive = 1'b1; // RULE6
                drv_d.ring_drive = 1'b1;
                drv_d.feed_on = 1'b1;
            end
            slf_pkg::SLF_FWD_OHT, slf_pkg::SLF_REV_OHT:
            begin
                drv_d.tip_drive = 1'b1;
                drv_d.ring_drive = 1'b1;
                drv_d.feed_on = 1'b1;
                drv_d.audio_on = 1'b1; // RULE7
            end
            slf_pkg::SLF_TIP_OPEN:
            begin
                drv_d.ring_drive = 1'b1; // RULE8
                drv_d.feed_on = 1'b1;
            end
            slf_pkg::SLF_RING_OPEN:
            begin
                drv_d.tip_drive = 1'b1; // RULE9
                drv_d.feed_on = 1'b1;
            end
            slf_pkg::SLF_RINGING:
            begin
                drv_d.tip_drive = 1'b1;
                drv_d.ring_drive = 1'b1;
                drv_d.ringing_on = 1'b1; // RULE10
            end
        endcase
        drv_d.reverse = (state_code == slf_pkg::SLF_REV_ACT) ||
                        (state_code == slf_pkg::SLF_REV_OHT); // RULE13
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            drv_q <= '0;
        else
            drv_q <= drv_d;
    end

    assign out.drv = drv_q;

    chk_open_no_drive: assert property (@(posedge ref_clk) // RULE3
        disable iff (!rstn)
        state_code == slf_pkg::SLF_OPEN
        |=> !drv_q.tip_drive && !drv_q.ring_drive && !drv_q.feed_on)
        else $error("open state still drives");
    chk_tip_open_ring: assert property (@(posedge ref_clk) // RULE8
        disable iff (!rstn)
        state_code == slf_pkg::SLF_TIP_OPEN
        |=> !drv_q.tip_drive && drv_q.ring_drive)
        else $error("tip open drive wrong");
endmodule
`default_nettype wire

// ===== slf_linefeed_ctrl.sv
// Linefeed control register bank and state control
//
// Notes on behaviour
// RULE1: Eight line states, code in register 0x40
// RULE2: Three-bit code decodes to eight fixed states
// RULE3: Open state removes all transistor drive
// RULE4: Power alarm can force open state
// RULE5: Alarm sets flag; opens only if enabled
// RULE6: Active states: feed on, audio off
// RULE7: On-hook transmission states power audio paths
// RULE8: Tip open: tip drive off, ring fed
// RULE9: Ring open: ring drive off, tip fed
// RULE10: Ringing state applies ringing waveform
// RULE11: Open-circuit voltage six bits, 1.5 V steps
// RULE12: Current limit three bits, 3 mA steps
// RULE13: Common-mode offset six bits, polarity headroom
// RULE14: Software configures feed before active states
// RULE15: Loop current and voltage readable continuously
// RULE16: Sense circuitry calibrates itself on chip
// RULE17: State readback shows code in force
`timescale 1ns/1ps
`include "slf_defines.svh"
`default_nettype none
module slf_linefeed_ctrl
#(
    parameter int CAL_CYC = `SLF_CAL_CYC
)
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic power_alarm_pin,
    input wire logic [6:0] loop_voltage_meas,
    input wire logic [6:0] loop_current_meas,
    input wire logic meas_valid,
    output logic tip_drive_en,
    output logic ring_drive_en,
    output logic feed_on,
    output logic audio_on,
    output logic ringing_on,
    output logic reverse_polarity,
    output logic [2:0] loop_current_limit,
    output logic [5:0] open_circuit_voltage,
    output logic [5:0] common_mode_offset,
    output logic power_alarm_irq,
    output logic cal_active
);
    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [2:0] line_state_code_q;
    logic [2:0] line_state_code_d;
    logic [2:0] loop_current_limit_q;
    logic [5:0] voc_q;
    logic [5:0] vcm_q;
    logic alarm_flag_q;
    logic alarm_flag_d;
    logic auto_open_enable_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [6:0] loopv_q;
    logic [6:0] loopi_q;
    logic alm_s1_q;
    logic alm_s2_q;
    logic alm_s3_q;
    logic vld_s1_q;
    logic vld_s2_q;
    logic [6:0] lv_s1_q;
    logic [6:0] lv_s2_q;
    logic [6:0] li_s1_q;
    logic [6:0] li_s2_q;
    logic [15:0] cal_cnt_q;
    logic cal_busy_q;

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    wire wr_state = reg_wr && hit(reg_addr, `SLF_OFF_STATE);
    wire wr_loop_current_limit = reg_wr && hit(reg_addr, `SLF_OFF_LOOP_CURRENT_LIMIT);
    wire wr_voc = reg_wr && hit(reg_addr, `SLF_OFF_VOC);
    wire wr_vcm = reg_wr && hit(reg_addr, `SLF_OFF_VCM);
    wire wr_alarm = reg_wr && hit(reg_addr, `SLF_OFF_ALARM);
    wire alarm_evt = alm_s2_q && !alm_s3_q;
    wire force_open = alarm_evt && auto_open_enable_q; // RULE4 RULE5
    wire alarm_clr = wr_alarm && reg_wdata[`SLF_ALM_FLAG_BIT];

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb
    begin
        line_state_code_d = line_state_code_q;
        if (wr_state)
            line_state_code_d = reg_wdata[`SLF_STATE_W-1:0]; // RULE1
        if (force_open)
            line_state_code_d = slf_pkg::SLF_OPEN; // RULE4
    end

    // Set wins over clear
    assign alarm_flag_d = alarm_evt ? 1'b1 :
        (alarm_clr ? 1'b0 : alarm_flag_q); // RULE5

    always_comb
    begin
        rdata_d = 8'h00;
        if (reg_rd)
        begin
            unique case (reg_addr)
                `SLF_OFF_STATE: rdata_d = {5'h00, line_state_code_q}; // RULE17
                `SLF_OFF_LOOP_CURRENT_LIMIT: rdata_d = {5'h00, loop_current_limit_q};
                `SLF_OFF_VOC: rdata_d = {2'h0, voc_q};
                `SLF_OFF_VCM: rdata_d = {2'h0, vcm_q};
                `SLF_OFF_ALARM: rdata_d = {5'h00, cal_busy_q,
                    auto_open_enable_q, alarm_flag_q};
                `SLF_OFF_LOOPV: rdata_d = {1'b0, loopv_q}; // RULE15
                `SLF_OFF_LOOPI: rdata_d = {1'b0, loopi_q}; // RULE15
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            line_state_code_q <= `SLF_RST_STATE;
            loop_current_limit_q <= `SLF_RST_LOOP_CURRENT_LIMIT;
            voc_q <= `SLF_RST_VOC;
            vcm_q <= `SLF_RST_VCM;
            alarm_flag_q <= 1'b0;
            auto_open_enable_q <= 1'b0;
            rdata_q <= 8'h00;
        end
        else
        begin
            line_state_code_q <= line_state_code_d;
            alarm_flag_q <= alarm_flag_d;
            rdata_q <= rdata_d;
            if (wr_loop_current_limit)
                loop_current_limit_q <= reg_wdata[`SLF_LOOP_CURRENT_LIMIT_W-1:0]; // RULE12
            if (wr_voc)
                voc_q <= reg_wdata[`SLF_VOC_W-1:0]; // RULE11
            if (wr_vcm)
                vcm_q <= reg_wdata[`SLF_VCM_W-1:0]; // RULE13
            if (wr_alarm)
                auto_open_enable_q <= reg_wdata[`SLF_ALM_AUTO_OPEN_ENABLE_BIT];
        end
    end

    // ---------------------------------------------------------------
    // Pin synchronisers and measurement capture
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            alm_s1_q <= 1'b0;
            alm_s2_q <= 1'b0;
            alm_s3_q <= 1'b0;
            vld_s1_q <= 1'b0;
            vld_s2_q <= 1'b0;
            lv_s1_q <= 7'h00;
            lv_s2_q <= 7'h00;
            li_s1_q <= 7'h00;
            li_s2_q <= 7'h00;
        end
        else
        begin
            alm_s1_q <= power_alarm_pin;
            alm_s2_q <= alm_s1_q;
            alm_s3_q <= alm_s2_q;
            vld_s1_q <= meas_valid;
            vld_s2_q <= vld_s1_q;
            lv_s1_q <= loop_voltage_meas;
            lv_s2_q <= lv_s1_q;
            li_s1_q <= loop_current_meas;
            li_s2_q <= li_s1_q;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            loopv_q <= 7'h00;
            loopi_q <= 7'h00;
        end
        else if (vld_s2_q && !cal_busy_q)
        begin
            loopv_q <= lv_s2_q; // RULE15
            loopi_q <= li_s2_q;
        end
    end

    // ---------------------------------------------------------------
    // Calibration after reset and on request from the alarm register
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            cal_cnt_q <= 16'h0000;
            cal_busy_q <= 1'b1;
        end
        else if (cal_busy_q)
        begin
            if (cal_cnt_q == 16'(CAL_CYC - 1))
                cal_busy_q <= 1'b0; // RULE16
            cal_cnt_q <= cal_cnt_q + 16'h0001;
        end
        else if (wr_alarm && reg_wdata[`SLF_ALM_CAL_BIT])
        begin
            cal_cnt_q <= 16'h0000;
            cal_busy_q <= 1'b1; // RULE16
        end
    end

    // ---------------------------------------------------------------
    // State decode and outputs
    // ---------------------------------------------------------------
    slf_drive_if drv_bus();

    slf_state_decode i_slf_state_decode
    (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .state_code(line_state_code_q),
        .out(drv_bus)
    );

    assign tip_drive_en = drv_bus.drv.tip_drive;
    assign ring_drive_en = drv_bus.drv.ring_drive;
    assign feed_on = drv_bus.drv.feed_on;
    assign audio_on = drv_bus.drv.audio_on;
    assign ringing_on = drv_bus.drv.ringing_on;
    assign reverse_polarity = drv_bus.drv.reverse;
    assign loop_current_limit = loop_current_limit_q;
    assign open_circuit_voltage = voc_q;
    assign common_mode_offset = vcm_q;
    assign power_alarm_irq = alarm_flag_q;
    assign cal_active = cal_busy_q;
    assign reg_rdata = rdata_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    chk_state_write: assert property (@(posedge ref_clk) // RULE1
        disable iff (!rstn)
        wr_state && !force_open
        |=> line_state_code_q == $past(reg_wdata[`SLF_STATE_W-1:0]))
        else $error("state write lost");
    chk_auto_open: assert property (@(posedge ref_clk) // RULE4
        disable iff (!rstn)
        force_open |=> line_state_code_q == slf_pkg::SLF_OPEN
        ##2 !tip_drive_en && !ring_drive_en)
        else $error("alarm did not open line");
    chk_alarm_flag: assert property (@(posedge ref_clk) // RULE5
        disable iff (!rstn)
        alarm_evt |=> alarm_flag_q)
        else $error("alarm flag not set");
    chk_alarm_clear: assert property (@(posedge ref_clk) // RULE5
        disable iff (!rstn)
        alarm_clr && !alarm_evt |=> !alarm_flag_q)
        else $error("alarm flag not cleared");
    chk_no_auto_open: assert property (@(posedge ref_clk) // RULE5
        disable iff (!rstn)
        alarm_evt && !auto_open_enable_q && !wr_state
        |=> $stable(line_state_code_q))
        else $error("line opened while disabled");
    chk_active_audio: assert property (@(posedge ref_clk) // RULE6
        disable iff (!rstn)
        line_state_code_q == slf_pkg::SLF_FWD_ACT
        && $stable(line_state_code_q)
        |=> feed_on && !audio_on && !reverse_polarity)
        else $error("active state drive wrong");
    chk_rev_polarity: assert property (@(posedge ref_clk) // RULE13
        disable iff (!rstn)
        line_state_code_q == slf_pkg::SLF_REV_ACT
        && $stable(line_state_code_q)
        |=> feed_on && !audio_on && reverse_polarity)
        else $error("reverse active drive wrong");
    chk_fwd_oht: assert property (@(posedge ref_clk) // RULE7
        disable iff (!rstn)
        line_state_code_q == slf_pkg::SLF_FWD_OHT
        && $stable(line_state_code_q)
        |=> audio_on && feed_on && !reverse_polarity)
        else $error("forward transmission audio off");
    chk_oht_audio: assert property (@(posedge ref_clk) // RULE7
        disable iff (!rstn)
        line_state_code_q == slf_pkg::SLF_REV_OHT
        && $stable(line_state_code_q)
        |=> audio_on && reverse_polarity)
        else $error("on-hook transmission audio off");
    chk_ring_open: assert property (@(posedge ref_clk) // RULE9
        disable iff (!rstn)
        line_state_code_q == slf_pkg::SLF_RING_OPEN
        && $stable(line_state_code_q)
        |=> tip_drive_en && !ring_drive_en)
        else $error("ring open drive wrong");
    chk_ringing_out: assert property (@(posedge ref_clk) // RULE10
        disable iff (!rstn)
        line_state_code_q == slf_pkg::SLF_RINGING
        && $stable(line_state_code_q)
        |=> ringing_on)
        else $error("ringing not applied");
    chk_voc_write: assert property (@(posedge ref_clk) // RULE11
        disable iff (!rstn)
        wr_voc
        |=> open_circuit_voltage == $past(reg_wdata[`SLF_VOC_W-1:0]))
        else $error("voltage setting lost");
    chk_loop_current_limit_write: assert property (@(posedge ref_clk) // RULE12
        disable iff (!rstn)
        wr_loop_current_limit
        |=> loop_current_limit == $past(reg_wdata[`SLF_LOOP_CURRENT_LIMIT_W-1:0]))
        else $error("current limit lost");
    chk_vcm_write: assert property (@(posedge ref_clk) // RULE13
        disable iff (!rstn)
        wr_vcm
        |=> common_mode_offset == $past(reg_wdata[`SLF_VCM_W-1:0]))
        else $error("offset setting lost");
    chk_meas_capture: assert property (@(posedge ref_clk) // RULE15
        disable iff (!rstn)
        vld_s2_q && !cal_busy_q
        |=> loopv_q == $past(lv_s2_q)
        && loopi_q == $past(li_s2_q))
        else $error("measurement not captured");
    chk_meas_hold: assert property (@(posedge ref_clk) // RULE16
        disable iff (!rstn)
        cal_busy_q |=> $stable(loopv_q) && $stable(loopi_q))
        else $error("measurement changed in calibration");
    chk_state_read: assert property (@(posedge ref_clk) // RULE17
        disable iff (!rstn)
        reg_rd && reg_addr == `SLF_OFF_STATE
        |=> reg_rdata == {5'h00, $past(line_state_code_q)})
        else $error("state readback wrong");

    cov_auto_open: cover property (@(posedge ref_clk) disable iff (!rstn)
        force_open);
    cov_alarm_kept: cover property (@(posedge ref_clk) disable iff (!rstn)
        alarm_evt && !auto_open_enable_q);
    cov_ringing: cover property (@(posedge ref_clk) disable iff (!rstn)
        ringing_on);
    cov_reverse_audio: cover property (@(posedge ref_clk) disable iff (!rstn)
        reverse_polarity && audio_on);
    cov_cal_done: cover property (@(posedge ref_clk) disable iff (!rstn)
        $fell(cal_busy_q));
endmodule
`default_nettype wire

// ===== slf_loop_model.sv
// Behavioural model of the subscriber loop: power alarm pin and loop measurements
`timescale 1ns/1ps
`default_nettype none
module slf_loop_model
(
    input wire logic ref_clk,
    input wire logic alarm_set,
    input wire logic meas_go,
    input wire logic [6:0] v_val,
    input wire logic [6:0] i_val,
    output logic power_alarm_pin,
    output logic [6:0] loop_voltage_meas,
    output logic [6:0] loop_current_meas,
    output logic meas_valid
);
    logic [3:0] hold_q;
    initial
    begin
        power_alarm_pin = 1'b0;
        meas_valid = 1'b0;
        hold_q = 4'h0;
        loop_voltage_meas = 7'h00;
        loop_current_meas = 7'h00;
    end
    // Data held past valid for the sync delay, then churns every cycle
    always @(posedge ref_clk)
    begin
        power_alarm_pin <= alarm_set;
        if (meas_go)
        begin
            hold_q <= 4'hc;
            loop_voltage_meas <= v_val;
            loop_current_meas <= i_val;
        end
        else if (hold_q != 4'h0)
            hold_q <= hold_q - 4'h1;
        else
        begin
            loop_voltage_meas <= ~loop_voltage_meas;
            loop_current_meas <= ~loop_current_meas;
        end
        meas_valid <= meas_go || (hold_q > 4'h4);
    end
endmodule
`default_nettype wire

// ===== subscriber_linefeed_control_tb.sv
// Self-checking testbench for the linefeed control block
`timescale 1ns/1ps
`include "slf_defines.svh"
`default_nettype none
module subscriber_linefeed_control_tb;
    typedef struct {logic [7:0] v; logic [7:0] m;} slf_rexp_s;
    logic ref_clk, rstn, reg_wr, reg_rd, alarm_set, meas_go, rd_d1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, w;
    logic [6:0] v_val, i_val, lvm, lcm;
    logic pa_pin, mv, tip, ring, feed, audio, rng, rev, irq, cal;
    logic [2:0] cur_lim;
    logic [5:0] ocv, cmo, drv_now;
    logic [5:0] drv_exp [8];
    logic [5:0] drv_mask [8];
    int n_errors, total_checks, seed, k, j;
    slf_rexp_s exp_q [$];
    slf_rexp_s rx;
    assign drv_now = {tip, ring, feed, audio, rng, rev};
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    slf_linefeed_ctrl #(.CAL_CYC(4)) i_slf_linefeed_ctrl
    (
        .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .power_alarm_pin(pa_pin),
        .loop_voltage_meas(lvm), .loop_current_meas(lcm), .meas_valid(mv),
        .tip_drive_en(tip), .ring_drive_en(ring), .feed_on(feed),
        .audio_on(audio), .ringing_on(rng), .reverse_polarity(rev),
        .loop_current_limit(cur_lim), .open_circuit_voltage(ocv),
        .common_mode_offset(cmo), .power_alarm_irq(irq), .cal_active(cal)
    );
    slf_loop_model i_slf_loop_model
    (
        .ref_clk(ref_clk), .alarm_set(alarm_set), .meas_go(meas_go),
        .v_val(v_val), .i_val(i_val), .power_alarm_pin(pa_pin),
        .loop_voltage_meas(lvm), .loop_current_meas(lcm), .meas_valid(mv)
    );
    // ---------------------------------------------------------------
    // Compare, bus and closing tasks
    // ---------------------------------------------------------------
    task complete_run;
        if (exp_q.size() != 0)
        begin
            n_errors++;
            $display("CHECK FAILED reg_rdata expected %0d more seen 0",
                     exp_q.size());
        end
        $display("Checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task check_port(input string nm, input logic [7:0] s,
                    input logic [7:0] e, input logic [7:0] m);
        total_checks++;
        if ((s & m) !== (e & m))
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e & m, s & m);
        end
    endtask
    task check_rd(input logic [7:0] s, input slf_rexp_s x);
        check_port("reg_rdata", s, x.v, x.m);
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        slf_rexp_s x;
        x.v = e;
        x.m = m;
        exp_q.push_back(x);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask
    task check_drv(input int s);
        tick(3);
        check_port("drive", {2'b00, drv_now}, {2'b00, drv_exp[s]},
                   {2'b00, drv_mask[s]});
    endtask
    task wait_cal;
        for (k = 0; k < 100 && cal !== 1'b0; k++)
            tick(1);
        if (cal !== 1'b0)
        begin
            n_errors++;
            $display("CHECK FAILED cal_active expected 0 seen %b", cal);
            complete_run;
        end
    endtask
    task raise_alarm;
        @(posedge ref_clk);
        alarm_set <= 1'b1;
        tick(8);
    endtask
    // ---------------------------------------------------------------
    // Read monitor: one result the cycle after each read strobe
    // ---------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        rd_d1 <= reg_rd;
        if (rd_d1 === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                n_errors++;
                $display("CHECK FAILED reg_rdata expected none seen %h",
                         reg_rdata);
            end
            else
            begin
                rx = exp_q.pop_front();
                check_rd(reg_rdata, rx);
            end
        end
    end
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        seed = 32'he232_1ef1;
        {rstn, reg_wr, reg_rd, alarm_set, meas_go} = 5'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        v_val = 7'h00;
        i_val = 7'h00;
        n_errors = 0;
        total_checks = 0;
        drv_exp = '{6'h00, 6'h38, 6'h34, 6'h10, 6'h02, 6'h39, 6'h35, 6'h20};
        drv_mask = '{6'h3f, 6'h3f, 6'h37, 6'h32, 6'h02, 6'h3f, 6'h37, 6'h32};
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        tick(1);
        check_port("cal_active", {7'h00, cal}, 8'h01, 8'h01);
        check_port("drive", {2'b00, drv_now}, 8'h00, 8'h3f);
        check_port("ocv", {2'b00, ocv}, 8'h20, 8'h3f);
        check_port("cmo", {2'b00, cmo}, 8'h02, 8'h3f);
        rd(`SLF_OFF_STATE, 8'h00, 8'h07);
        rd(8'h47, 8'h00, 8'h07);
        wait_cal();
        rd(8'h41, 8'h00, 8'hff);
        wr(8'h41, 8'hff);
        rd(`SLF_OFF_STATE, 8'h00, 8'h07);
        // Feed set up before any active state
        for (j = 0; j < 3; j++)
        begin
            k = $random(seed);
            w = (j == 0) ? k[7:0] : ((j == 1) ? 8'h00 : 8'hff);
            wr(8'h47, w);
            wr(8'h48, w ^ 8'h15);
            wr(8'h49, w ^ 8'h2a);
            rd(8'h47, w, 8'h07);
            rd(8'h48, w ^ 8'h15, 8'h3f);
            rd(8'h49, w ^ 8'h2a, 8'h3f);
            tick(2);
            check_port("cur_lim", {5'h00, cur_lim}, w, 8'h07);
            check_port("ocv", {2'b00, ocv}, w ^ 8'h15, 8'h3f);
            check_port("cmo", {2'b00, cmo}, w ^ 8'h2a, 8'h3f);
        end
        for (j = 0; j < 16; j++)
        begin
            k = (j < 8) ? j : ($random(seed) & 7);
            wr(`SLF_OFF_STATE, 8'(k) | 8'hf8);
            check_drv(k);
            rd(`SLF_OFF_STATE, 8'(k), 8'h07);
        end
        k = $random(seed);
        v_val = k[6:0];
        i_val = k[14:8];
        @(posedge ref_clk);
        meas_go <= 1'b1;
        @(posedge ref_clk);
        meas_go <= 1'b0;
        tick(16);
        rd(`SLF_OFF_LOOPV, {1'b0, v_val}, 8'h7f);
        rd(`SLF_OFF_LOOPI, {1'b0, i_val}, 8'h7f);
        wr(`SLF_OFF_ALARM, 8'h04);
        tick(2);
        check_port("cal_active", {7'h00, cal}, 8'h01, 8'h01);
        wait_cal();
        wr(`SLF_OFF_STATE, 8'h01);
        raise_alarm();
        check_port("irq", {7'h00, irq}, 8'h01, 8'h01);
        rd(`SLF_OFF_ALARM, 8'h01, 8'h03);
        rd(`SLF_OFF_STATE, 8'h01, 8'h07);
        check_drv(1);
        @(posedge ref_clk);
        alarm_set <= 1'b0;
        tick(4);
        wr(`SLF_OFF_ALARM, 8'h03);
        tick(1);
        check_port("irq", {7'h00, irq}, 8'h00, 8'h01);
        wr(`SLF_OFF_STATE, 8'h05);
        raise_alarm();
        rd(`SLF_OFF_STATE, 8'h00, 8'h07);
        rd(`SLF_OFF_ALARM, 8'h03, 8'h03);
        check_drv(0);
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(`SLF_OFF_STATE, 8'h00, 8'h07);
        rd(8'h48, 8'h20, 8'h3f);
        tick(4);
        complete_run();
    end
endmodule
`default_nettype wire
